// *** include/fsrp_regs.svh ***
// constants of the flash sector read protection block
// Notes on behaviour
// - flash reads and fetches wait while an erase or write runs
// - once the application starts, vectors come from user flash
// - programming neither uses nor changes the interrupt enable
// - serial programming handler owns RAM 017C to 025B
// - top 32 RAM bytes reserved; handler stack below, 256 bytes down
// - application programming uses at most 128 bytes of caller stack
// - USB shows flash as one file; delete then copy replaces code
// - levels one and two erase user flash on file delete
// - none or level one: copy erases and writes only covered area
// - USB volume label reports the active protection level
// - without protection USB may read and write user flash
// - levels one and two forbid reads, allow updates
// - level two erases all user flash before writing an image
// - level three forbids reads and updates; valid user code always runs
// - 4 kB sectors from address zero, sector n at n times 0x1000
// - protection level comes from the flash word at 0x02FC
// - application programming works at every protection level
// - a new protection pattern acts only after a power cycle
// - three patterns select levels one to three; each blocks debug
// - one pattern stops boot code sampling the boot select pin
// - one ECC byte per 16 bytes; writes are aligned 16-byte groups
`ifndef FSRP_REGS_SVH
`define FSRP_REGS_SVH

// ========
// flash layout
`define FSRP_AW 15
`define FSRP_LEVEL_WORD 15'h02FC
`define FSRP_SECTORS 8
`define FSRP_SECTOR_IW 3
`define FSRP_SECTOR_BITS 12
`define FSRP_SECTOR_BYTES 16'h1000
`define FSRP_FILE_BYTES 16'h8000
`define FSRP_GROUP_BITS 4
`define FSRP_VEC_BYTES 15'h0200

// ========
// protection patterns
`define FSRP_PAT_ONE 32'h12345678
`define FSRP_PAT_TWO 32'h87654321
`define FSRP_PAT_THREE 32'h43218765
`define FSRP_PAT_PIN_OFF 32'h4E697370

// ========
// on-chip RAM use of the programming handlers
`define FSRP_RAM_AW 13
`define FSRP_RAM_TOP 13'h1FFF
`define FSRP_ISP_RAM_LO 13'h017C
`define FSRP_ISP_RAM_HI 13'h025B
`define FSRP_PROG_RESERVE 13'h0020
`define FSRP_ISP_STACK 13'h0100
`define FSRP_IAP_STACK 13'h0080

`endif

// *** include/fsrp_pkg.sv ***
// types of the flash sector read protection block
package fsrp_pkg;

    // ========
    // protection level, also the volume label code
    typedef enum logic [1:0] {
        LVL_NONE = 2'h0,
        LVL_ONE = 2'h1,
        LVL_TWO = 2'h2,
        LVL_THREE = 2'h3
    } fsrp_level_t;

    // ========
    // sequencer states, gray along level read, idle, read/write/erase
    typedef enum logic [2:0] {
        ST_LVL = 3'h0,
        ST_IDLE = 3'h1,
        ST_READ = 3'h3,
        ST_WRITE = 3'h2,
        ST_ERASE = 3'h6
    } fsrp_state_t;

    // ========
    // flash macro operations and requester commands
    typedef enum logic [1:0] {
        FOP_READ = 2'h0,
        FOP_WRITE = 2'h1,
        FOP_ERASE = 2'h2
    } fsrp_fop_t;

    typedef enum logic {
        IAP_ERASE = 1'h0,
        IAP_WRITE = 1'h1
    } fsrp_iap_op_t;

    typedef enum logic [1:0] {
        UC_READ = 2'h0,
        UC_DELETE = 2'h1,
        UC_COPY = 2'h2,
        UC_WRITE = 2'h3
    } fsrp_usb_cmd_t;

endpackage

// *** rtl/fsrp_sector_dec.sv ***
// sector decode of a flash address and of an image length
`timescale 1ns/100ps
`include "fsrp_regs.svh"

module fsrp_sector_dec (
    input wire logic [`FSRP_AW-1:0] addr,
    input wire logic [15:0] len,
    output logic [`FSRP_SECTOR_IW-1:0] sector,
    output logic in_range,
    output logic [`FSRP_SECTORS-1:0] sec_cover
);

    // ========
    // sector number and range check
    // sector n spans n*0x1000 to n*0x1000+0xFFF
    assign sector = addr[`FSRP_AW-1:`FSRP_SECTOR_BITS];
    assign in_range = {1'b0, addr} < `FSRP_FILE_BYTES;

    // ========
    // sectors touched by an image of len bytes from address zero
    genvar i;
    generate
        for (i = 0; i < `FSRP_SECTORS; i++) begin : g_cov
            // only the area the new file occupies
            assign sec_cover[i] = len > (16'(i) * `FSRP_SECTOR_BYTES);
        end
    endgenerate

endmodule

// *** rtl/fsrp_top.sv ***
// flash sector read protection and update sequencer
`timescale 1ns/100ps
`include "fsrp_regs.svh"

module fsrp_top (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic por_n,
    input wire logic app_started,
    input wire logic cpu_rd_req,
    input wire logic [`FSRP_AW-1:0] cpu_addr,
    output logic cpu_rd_valid,
    output logic cpu_stall,
    output logic [31:0] rd_data,
    output logic vec_from_user,
    input wire logic iap_req,
    input wire fsrp_pkg::fsrp_iap_op_t iap_op,
    input wire logic [`FSRP_AW-1:0] iap_addr,
    input wire logic [`FSRP_SECTORS-1:0] iap_mask,
    input wire logic [127:0] iap_wdata,
    output logic iap_done,
    output logic iap_err,
    input wire logic usb_req,
    input wire fsrp_pkg::fsrp_usb_cmd_t usb_cmd,
    input wire logic [`FSRP_AW-1:0] usb_addr,
    input wire logic [15:0] usb_len,
    input wire logic [127:0] usb_wdata,
    output logic usb_done,
    output logic usb_refused,
    output logic usb_rd_valid,
    output fsrp_pkg::fsrp_level_t usb_volume_level,
    output logic [15:0] usb_file_bytes,
    output logic debug_off,
    output logic boot_pin_sampling_off,
    output logic run_user_always,
    input wire logic ram_wr_en,
    input wire logic [`FSRP_RAM_AW-1:0] ram_addr,
    input wire logic isp_active,
    input wire logic [`FSRP_RAM_AW-1:0] cpu_sp,
    output logic ram_clash,
    output logic fl_req,
    output fsrp_pkg::fsrp_fop_t fl_op,
    output logic [`FSRP_AW-1:0] fl_addr,
    output logic [127:0] fl_wdata,
    output logic fl_boot_sel,
    input wire logic fl_done,
    input wire logic [31:0] fl_rdata
);

    // ========
    // helper functions
    // lowest sector still marked for erase
    function automatic logic [`FSRP_SECTOR_IW-1:0] lowest_set(
        input logic [`FSRP_SECTORS-1:0] m
    );
        logic [`FSRP_SECTOR_IW-1:0] r;
        r = '0;
        for (int i = `FSRP_SECTORS - 1; i >= 0; i--) begin
            if (m[i]) begin
                r = `FSRP_SECTOR_IW'(i);
            end
        end
        return r;
    endfunction

    // address inside an inclusive RAM window
    function automatic logic in_win(
        input logic [`FSRP_RAM_AW-1:0] a,
        input logic [`FSRP_RAM_AW-1:0] lo,
        input logic [`FSRP_RAM_AW-1:0] hi
    );
        return (a >= lo) && (a <= hi);
    endfunction

    // ========
    // declarations
    fsrp_pkg::fsrp_state_t st_q, st_d;
    fsrp_pkg::fsrp_level_t lvl_q, lvl_d;
    fsrp_pkg::fsrp_fop_t fl_op_q, fl_op_d;
    logic lvl_known_q, lvl_known_d;
    logic pin_off_q, pin_off_d;
    logic dbg_off_q, dbg_off_d;
    logic run_user_q, run_user_d;
    logic [15:0] file_bytes_q, file_bytes_d;
    logic fl_req_q, fl_req_d;
    logic [`FSRP_AW-1:0] fl_addr_q, fl_addr_d;
    logic [127:0] fl_wdata_q, fl_wdata_d;
    logic boot_sel_q, boot_sel_d;
    logic [`FSRP_SECTORS-1:0] mask_q, mask_d;
    logic src_usb_q, src_usb_d;
    logic [31:0] rd_data_q, rd_data_d;
    logic cpu_valid_q, cpu_valid_d;
    logic usb_valid_q, usb_valid_d;
    logic iap_done_q, iap_done_d;
    logic iap_err_q, iap_err_d;
    logic usb_done_q, usb_done_d;
    logic usb_ref_q, usb_ref_d;
    logic stall_q, stall_d;
    logic user_vec_q, user_vec_d;
    logic clash_q, clash_d;
    logic answer_q;
    logic iap_busy;
    logic usb_in_range;
    logic [`FSRP_SECTORS-1:0] usb_cover;
    logic [`FSRP_SECTOR_IW-1:0] erase_idx;

    // ========
    // sector decode of the usb side
    fsrp_sector_dec u_dec (
        .addr(usb_addr),
        .len(usb_len),
        .sector(),
        .in_range(usb_in_range),
        .sec_cover(usb_cover)
    );

    // ========
    // protection level, kept across warm resets
    // capture the level word once per power-up
    always_comb begin
        lvl_d = lvl_q;
        lvl_known_d = lvl_known_q;
        pin_off_d = pin_off_q;
        dbg_off_d = dbg_off_q;
        run_user_d = run_user_q;
        file_bytes_d = file_bytes_q;
        if (st_q == fsrp_pkg::ST_LVL && fl_req_q && fl_done) begin
            lvl_known_d = 1'b1;
            unique case (fl_rdata)
                `FSRP_PAT_ONE: lvl_d = fsrp_pkg::LVL_ONE;
                `FSRP_PAT_TWO: lvl_d = fsrp_pkg::LVL_TWO;
                `FSRP_PAT_THREE: lvl_d = fsrp_pkg::LVL_THREE;
                default: lvl_d = fsrp_pkg::LVL_NONE;
            endcase
            pin_off_d = fl_rdata == `FSRP_PAT_PIN_OFF;
            dbg_off_d = lvl_d != fsrp_pkg::LVL_NONE;
            run_user_d = lvl_d == fsrp_pkg::LVL_THREE;
        end
    end

    // only the power-on reset initialises these
    always_ff @(posedge clk or negedge por_n) begin
        if (!por_n) begin
            lvl_q <= fsrp_pkg::LVL_THREE;
            lvl_known_q <= 1'b0;
            pin_off_q <= 1'b0;
            dbg_off_q <= 1'b1;
            run_user_q <= 1'b0;
            file_bytes_q <= `FSRP_FILE_BYTES;
        end else begin
            lvl_q <= lvl_d;
            lvl_known_q <= lvl_known_d;
            pin_off_q <= pin_off_d;
            dbg_off_q <= dbg_off_d;
            run_user_q <= run_user_d;
            file_bytes_q <= file_bytes_d;
        end
    end

    // ========
    // request sequencer
    // a request is not taken while an answer pulse is out
    assign answer_q = cpu_valid_q | usb_valid_q | iap_done_q | iap_err_q
        | usb_done_q | usb_ref_q;
    assign erase_idx = lowest_set(mask_q);

    // next state, flash command and answers
    always_comb begin
        st_d = st_q;
        fl_req_d = fl_req_q;
        fl_op_d = fl_op_q;
        fl_addr_d = fl_addr_q;
        fl_wdata_d = fl_wdata_q;
        boot_sel_d = boot_sel_q;
        mask_d = mask_q;
        src_usb_d = src_usb_q;
        rd_data_d = rd_data_q;
        cpu_valid_d = 1'b0;
        usb_valid_d = 1'b0;
        iap_done_d = 1'b0;
        iap_err_d = 1'b0;
        usb_done_d = 1'b0;
        usb_ref_d = 1'b0;
        user_vec_d = user_vec_q | app_started;
        unique case (st_q)
            fsrp_pkg::ST_LVL: begin
                if (lvl_known_q) begin
                    st_d = fsrp_pkg::ST_IDLE;
                end else if (!fl_req_q) begin
                    fl_req_d = 1'b1;
                    fl_op_d = fsrp_pkg::FOP_READ;
                    fl_addr_d = `FSRP_LEVEL_WORD;
                    boot_sel_d = 1'b0;
                end else if (fl_done) begin
                    fl_req_d = 1'b0;
                    st_d = fsrp_pkg::ST_IDLE;
                end
            end
            fsrp_pkg::ST_IDLE: begin
                if (!answer_q && iap_req) begin
                    // no level check here; the routine also leaves the
                    // interrupt enable alone
                    src_usb_d = 1'b0;
                    boot_sel_d = 1'b0;
                    if (iap_op == fsrp_pkg::IAP_ERASE) begin
                        mask_d = iap_mask;
                        st_d = fsrp_pkg::ST_ERASE;
                    end else if (iap_addr[`FSRP_GROUP_BITS-1:0] != '0) begin
                        iap_err_d = 1'b1;
                    end else begin
                        fl_req_d = 1'b1;
                        fl_op_d = fsrp_pkg::FOP_WRITE;
                        fl_addr_d = iap_addr;
                        fl_wdata_d = iap_wdata;
                        st_d = fsrp_pkg::ST_WRITE;
                    end
                end else if (!answer_q && cpu_rd_req) begin
                    src_usb_d = 1'b0;
                    fl_req_d = 1'b1;
                    fl_op_d = fsrp_pkg::FOP_READ;
                    fl_addr_d = cpu_addr;
                    // low vectors from boot area until the app runs
                    boot_sel_d = !user_vec_q
                        && (cpu_addr < `FSRP_VEC_BYTES);
                    st_d = fsrp_pkg::ST_READ;
                end else if (!answer_q && usb_req) begin
                    src_usb_d = 1'b1;
                    boot_sel_d = 1'b0;
                    unique case (usb_cmd)
                        fsrp_pkg::UC_READ: begin
                            // reads only when unprotected
                            if (lvl_q == fsrp_pkg::LVL_NONE
                                && usb_in_range) begin
                                fl_req_d = 1'b1;
                                fl_op_d = fsrp_pkg::FOP_READ;
                                fl_addr_d = usb_addr;
                                st_d = fsrp_pkg::ST_READ;
                            end else begin
                                usb_ref_d = 1'b1;
                            end
                        end
                        fsrp_pkg::UC_DELETE: begin
                            if (lvl_q == fsrp_pkg::LVL_THREE) begin
                                usb_ref_d = 1'b1;
                            end else if (lvl_q != fsrp_pkg::LVL_NONE) begin
                                mask_d = '1;
                                st_d = fsrp_pkg::ST_ERASE;
                            end else begin
                                usb_done_d = 1'b1;
                            end
                        end
                        fsrp_pkg::UC_COPY: begin
                            // file name plays no part
                            if (lvl_q == fsrp_pkg::LVL_THREE) begin
                                usb_ref_d = 1'b1;
                            end else if (lvl_q == fsrp_pkg::LVL_TWO) begin
                                mask_d = '1;
                                st_d = fsrp_pkg::ST_ERASE;
                            end else begin
                                mask_d = usb_cover;
                                st_d = fsrp_pkg::ST_ERASE;
                            end
                        end
                        fsrp_pkg::UC_WRITE: begin
                            if (lvl_q == fsrp_pkg::LVL_THREE
                                || !usb_in_range
                                || usb_addr[`FSRP_GROUP_BITS-1:0] != '0)
                            begin
                                usb_ref_d = 1'b1;
                            end else begin
                                fl_req_d = 1'b1;
                                fl_op_d = fsrp_pkg::FOP_WRITE;
                                fl_addr_d = usb_addr;
                                fl_wdata_d = usb_wdata;
                                st_d = fsrp_pkg::ST_WRITE;
                            end
                        end
                    endcase
                end
            end
            fsrp_pkg::ST_READ: begin
                if (fl_done) begin
                    fl_req_d = 1'b0;
                    rd_data_d = fl_rdata;
                    usb_valid_d = src_usb_q;
                    cpu_valid_d = !src_usb_q;
                    st_d = fsrp_pkg::ST_IDLE;
                end
            end
            fsrp_pkg::ST_WRITE: begin
                if (fl_done) begin
                    fl_req_d = 1'b0;
                    usb_done_d = src_usb_q;
                    iap_done_d = !src_usb_q;
                    st_d = fsrp_pkg::ST_IDLE;
                end
            end
            fsrp_pkg::ST_ERASE: begin
                // one sector at a time, lowest first
                if (!fl_req_q && mask_q == '0) begin
                    usb_done_d = src_usb_q;
                    iap_done_d = !src_usb_q;
                    st_d = fsrp_pkg::ST_IDLE;
                end else if (!fl_req_q) begin
                    fl_req_d = 1'b1;
                    fl_op_d = fsrp_pkg::FOP_ERASE;
                    fl_addr_d = {erase_idx,
                        {`FSRP_SECTOR_BITS{1'b0}}};
                end else if (fl_done) begin
                    fl_req_d = 1'b0;
                    mask_d[erase_idx] = 1'b0;
                end
            end
            default: begin
                fl_req_d = 1'b0;
                st_d = fsrp_pkg::ST_IDLE;
            end
        endcase
        // fetches wait out any erase, write or level read
        stall_d = (st_d == fsrp_pkg::ST_ERASE)
            || (st_d == fsrp_pkg::ST_WRITE)
            || (st_d == fsrp_pkg::ST_LVL);
    end

    // sequencer registers
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st_q <= fsrp_pkg::ST_LVL;
            fl_req_q <= 1'b0;
            fl_op_q <= fsrp_pkg::FOP_READ;
            fl_addr_q <= '0;
            fl_wdata_q <= '0;
            boot_sel_q <= 1'b0;
            mask_q <= '0;
            src_usb_q <= 1'b0;
            rd_data_q <= 32'h0;
            cpu_valid_q <= 1'b0;
            usb_valid_q <= 1'b0;
            iap_done_q <= 1'b0;
            iap_err_q <= 1'b0;
            usb_done_q <= 1'b0;
            usb_ref_q <= 1'b0;
            stall_q <= 1'b1;
            user_vec_q <= 1'b0;
        end else begin
            st_q <= st_d;
            fl_req_q <= fl_req_d;
            fl_op_q <= fl_op_d;
            fl_addr_q <= fl_addr_d;
            fl_wdata_q <= fl_wdata_d;
            boot_sel_q <= boot_sel_d;
            mask_q <= mask_d;
            src_usb_q <= src_usb_d;
            rd_data_q <= rd_data_d;
            cpu_valid_q <= cpu_valid_d;
            usb_valid_q <= usb_valid_d;
            iap_done_q <= iap_done_d;
            iap_err_q <= iap_err_d;
            usb_done_q <= usb_done_d;
            usb_ref_q <= usb_ref_d;
            stall_q <= stall_d;
            user_vec_q <= user_vec_d;
        end
    end

    // ========
    // guard of RAM owned by the programming handlers
    // application programming in flight
    assign iap_busy = !src_usb_q && ((st_q == fsrp_pkg::ST_ERASE)
        || (st_q == fsrp_pkg::ST_WRITE));

    // flag a foreign write into handler-owned RAM
    always_comb begin
        clash_d = 1'b0;
        if (ram_wr_en && isp_active) begin
            clash_d = in_win(ram_addr, `FSRP_ISP_RAM_LO,
                    `FSRP_ISP_RAM_HI)
                || in_win(ram_addr, `FSRP_RAM_TOP - `FSRP_PROG_RESERVE
                    - `FSRP_ISP_STACK + 13'h1, `FSRP_RAM_TOP);
        end
        if (ram_wr_en && iap_busy) begin
            clash_d = clash_d
                || in_win(ram_addr, `FSRP_RAM_TOP - `FSRP_PROG_RESERVE
                    + 13'h1, `FSRP_RAM_TOP)
                || in_win(ram_addr, cpu_sp - `FSRP_IAP_STACK,
                    cpu_sp - 13'h1);
        end
    end

    // guard flag register
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            clash_q <= 1'b0;
        end else begin
            clash_q <= clash_d;
        end
    end

    // ========
    // outputs, each straight from a flip-flop
    assign cpu_rd_valid = cpu_valid_q;
    assign cpu_stall = stall_q;
    assign rd_data = rd_data_q;
    assign vec_from_user = user_vec_q;
    assign iap_done = iap_done_q;
    assign iap_err = iap_err_q;
    assign usb_done = usb_done_q;
    assign usb_refused = usb_ref_q;
    assign usb_rd_valid = usb_valid_q;
    assign usb_volume_level = lvl_q;
    assign usb_file_bytes = file_bytes_q;
    assign debug_off = dbg_off_q;
    assign boot_pin_sampling_off = pin_off_q;
    assign run_user_always = run_user_q;
    assign ram_clash = clash_q;
    assign fl_req = fl_req_q;
    assign fl_op = fl_op_q;
    assign fl_addr = fl_addr_q;
    assign fl_wdata = fl_wdata_q;
    assign fl_boot_sel = boot_sel_q;

endmodule

// *** dv/fsrp_props.sv ***
// assertions on the ports of the flash read protection block
`timescale 1ns/100ps
module fsrp_props (
    input wire logic clk, reset_n, por_n, app_started, vec_from_user,
    input wire logic iap_req, iap_err, usb_done, debug_off,
    input wire fsrp_pkg::fsrp_iap_op_t iap_op,
    input wire logic [14:0] iap_addr, fl_addr,
    input wire fsrp_pkg::fsrp_level_t usb_volume_level,
    input wire fsrp_pkg::fsrp_fop_t fl_op,
    input wire logic run_user_always, cpu_rd_valid, cpu_stall, fl_req,
    input wire logic fl_done, ram_wr_en, isp_active, ram_clash,
    input wire logic [12:0] ram_addr
);
    // ========
    // properties
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n || !por_n);
    sequence s_misal;
        $rose(iap_req) && iap_op == fsrp_pkg::IAP_WRITE
            && iap_addr[3:0] != 4'h0;
    endsequence
    property p_err; s_misal |-> ##[1:4] iap_err; endproperty
    property p_busy;
        fl_req && fl_op != fsrp_pkg::FOP_READ |-> cpu_stall && !cpu_rd_valid;
    endproperty
    property p_vec; app_started |=> vec_from_user; endproperty
    property p_dbg;
        debug_off == (usb_volume_level != fsrp_pkg::LVL_NONE);
    endproperty
    property p_run;
        run_user_always |-> usb_volume_level == fsrp_pkg::LVL_THREE;
    endproperty
    property p_lvl3;
        usb_done |-> usb_volume_level != fsrp_pkg::LVL_THREE;
    endproperty
    property p_sec;
        fl_req && fl_op == fsrp_pkg::FOP_ERASE |-> fl_addr[11:0] == 12'h000;
    endproperty
    property p_grp;
        fl_req && fl_op == fsrp_pkg::FOP_WRITE |-> fl_addr[3:0] == 4'h0;
    endproperty
    property p_hold;
        $changed(usb_volume_level) |-> $past(fl_done && fl_addr == 15'h02FC);
    endproperty
    property p_ram;
        isp_active && ram_wr_en && ram_addr >= 13'h017C
            && ram_addr <= 13'h025B |=> ram_clash;
    endproperty
    a_err: assert property (p_err) else $error("no error");
    a_busy: assert property (p_busy) else $error("busy read");
    a_vec: assert property (p_vec) else $error("vector source");
    a_dbg: assert property (p_dbg) else $error("debug");
    a_run: assert property (p_run) else $error("run user");
    a_lvl3: assert property (p_lvl3) else $error("lvl3 update");
    a_sec: assert property (p_sec) else $error("erase addr");
    a_grp: assert property (p_grp) else $error("write addr");
    a_hold: assert property (p_hold) else $error("level changed");
    a_ram: assert property (p_ram) else $error("RAM hit missed");
endmodule

bind fsrp_top fsrp_props u_props (.*);

// *** dv/fsrp_flash_model.sv ***
// flash macro model answering the block's flash requests
`timescale 1ns/100ps
module fsrp_flash_model (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic fl_req,
    input wire logic [14:0] fl_addr,
    input wire logic [31:0] prot_word,
    output logic fl_done,
    output logic [31:0] fl_rdata
);
    logic [2:0] cnt, dly;
    // answer after a random wait, data valid only with done
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            {fl_done, cnt, dly} <= 7'h00;
            fl_rdata <= 32'h0;
        end else if (!fl_done && fl_req && cnt == dly) begin
            fl_done <= 1'b1;
            cnt <= 3'h0;
            dly <= 3'($urandom_range(0, 5));
            fl_rdata <= fl_addr == 15'h02FC ? prot_word : {fl_addr, 2'h0, fl_addr};
        end else begin
            fl_done <= 1'b0;
            cnt <= fl_req && !fl_done ? cnt + 3'h1 : 3'h0;
            fl_rdata <= ~fl_rdata; // data lines not held
        end
    end
endmodule

// *** dv/tb_fsrp_top.sv ***
// testbench of the flash read protection block
`timescale 1ns/100ps
`include "fsrp_regs.svh"
module tb_fsrp_top;
    logic clk = 0, reset_n = 0, por_n = 0, app_started = 0;
    logic cpu_rd_req = 0, iap_req = 0, usb_req = 0;
    logic [14:0] cpu_addr = 0, iap_addr = 0, usb_addr = 0, fl_addr;
    logic [7:0] iap_mask = 0;
    logic [127:0] wdata = 0, fl_wdata;
    logic [15:0] usb_len = 0, usb_file_bytes;
    logic ram_wr_en = 0, isp_active = 0, ram_clash, fl_req, fl_done;
    logic [12:0] ram_addr = 0, cpu_sp = 0;
    fsrp_pkg::fsrp_iap_op_t iap_op = fsrp_pkg::IAP_ERASE;
    fsrp_pkg::fsrp_usb_cmd_t usb_cmd = fsrp_pkg::UC_READ;
    fsrp_pkg::fsrp_level_t usb_volume_level;
    fsrp_pkg::fsrp_fop_t fl_op;
    logic cpu_rd_valid, cpu_stall, vec_from_user, iap_done, iap_err;
    logic usb_done, usb_refused, usb_rd_valid, debug_off, fl_boot_sel;
    logic boot_pin_sampling_off, run_user_always;
    logic [31:0] rd_data, fl_rdata, prot_word = 0;
    logic [31:0] pats [5];
    logic [2:0] r, e;
    logic [1:0] lv;
    int fails = 0, n_checks = 0, n_er = 0, cyc = 0;

    fsrp_top DUT (.*, .iap_wdata(wdata), .usb_wdata(wdata));
    fsrp_flash_model u_flash (.*);

    // ========
    // clock, erase counter, random RAM traffic and timeout
    initial forever #5 clk = ~clk;
    always @(posedge clk) if (fl_done && fl_op == fsrp_pkg::FOP_ERASE) n_er++;
    always @(negedge clk) begin
        {cpu_sp, ram_wr_en, isp_active, ram_addr} <= 28'($urandom);
        wdata <= {4{$urandom}};
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            fails++;
            wrap_up;
        end
    end

    // ========
    // helpers
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: seen %h expected %h", $time, got, exp);
        end
    endtask
    function automatic logic [1:0] lvl_of(input logic [31:0] w);
        case (w)
            `FSRP_PAT_ONE: return 2'h1;
            `FSRP_PAT_TWO: return 2'h2;
            `FSRP_PAT_THREE: return 2'h3;
            default: return 2'h0;
        endcase
    endfunction
    task automatic rst(input logic por);
        int n = 0;
        @(negedge clk);
        {reset_n, por_n} = {1'b0, !por};
        repeat (4) @(negedge clk);
        {reset_n, por_n} = 2'h3;
        while (cpu_stall !== 1'b0 && n < 200) begin
            @(negedge clk);
            n++;
        end
    endtask
    // request on port p (0 cpu, 1 iap, 2 usb), result {err, done, data}
    task automatic go(input int p,
                      input fsrp_pkg::fsrp_usb_cmd_t c = fsrp_pkg::UC_READ);
        int n = 0;
        @(negedge clk);
        usb_cmd = c;
        n_er = 0;
        r = 3'h0;
        {usb_req, iap_req, cpu_rd_req} = 3'h1 << p;
        while (r === 3'h0 && n < 3000) begin
            @(negedge clk);
            n++;
            r = p == 0 ? {2'h0, cpu_rd_valid}
                : p == 1 ? {iap_err, iap_done, 1'b0}
                : {usb_refused, usb_done, usb_rd_valid};
        end
        {usb_req, iap_req, cpu_rd_req} = 3'h0;
        if (n >= 3000) fails++;
    endtask
    task wrap_up;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    // ========
    // every protection pattern after a power cycle
    initial begin
        void'($urandom(9));
        pats = '{`FSRP_PAT_ONE, `FSRP_PAT_TWO, `FSRP_PAT_THREE,
                 `FSRP_PAT_PIN_OFF, $urandom};
        for (int i = 0; i < 5; i++) begin
            prot_word = pats[i];
            rst(1'b1);
            lv = lvl_of(prot_word);
            e = lv == 2'h3 ? 3'h4 : 3'h2;
            chk(usb_volume_level, lv);
            chk(run_user_always, lv == 2'h3);
            chk(boot_pin_sampling_off,
                prot_word == `FSRP_PAT_PIN_OFF);
            chk(usb_file_bytes, 16'h8000);
            usb_addr = 15'($urandom);
            go(2);
            chk(r, lv == 2'h0 ? 3'h1 : 3'h4);
            go(2, fsrp_pkg::UC_DELETE);
            chk(r, e);
            chk(n_er, lv == 2'h1 || lv == 2'h2 ? 8 : 0);
            usb_len = 16'($urandom_range(1, 32768));
            go(2, fsrp_pkg::UC_COPY);
            chk(n_er, lv == 2'h3 ? 0 : lv == 2'h2 ? 8
                : (usb_len + 4095) >> 12);
            usb_addr = 15'h0000;
            go(2, fsrp_pkg::UC_WRITE);
            chk(r, e);
            usb_addr = 15'h0008;
            go(2, fsrp_pkg::UC_WRITE);
            chk(r, 3'h4);
            cpu_addr = 15'($urandom) & (i[0] ? 15'h7FF0 : 15'h01F0);
            go(0);
            chk(rd_data, {cpu_addr, 2'h0, cpu_addr});
            chk(fl_boot_sel, cpu_addr < 15'h0200);
            iap_op = fsrp_pkg::IAP_WRITE;
            iap_addr = 15'h0104;
            go(1);
            chk(r, 3'h4);
            iap_op = fsrp_pkg::IAP_ERASE;
            iap_mask = 8'($urandom);
            go(1);
            chk(n_er, $countones(iap_mask));
            prot_word = pats[(i + 1) % 5];
            rst(1'b0);
            chk(usb_volume_level, lv);
            app_started = 1'b1;
            @(negedge clk);
            app_started = 1'b0;
            chk(vec_from_user, 1'b1);
        end
        wrap_up;
    end
endmodule
